// >>> hw/mfio_ports.sv
// Top: parallel ports 1 to 4 with APB register access and pin interrupt
//
// Added by the designer: the APB slave port.
`timescale 1ns/100ps
// What this block does
// - Port one bits individually input or output
// - Port one direction and latch reset zero
// - Port one read: latch if output, else pin
// - Read-modify-write may overwrite input latch bits
// - Input pins ignore latch, direction zero
// - Port two three pins, latch resets ones
// - Dual-clock mode gives pins to crystal
// - Pin zero falling edge always sets latch
// - Port two upper read bits undefined
// - Ports two-four: latch read and pin read
// - Stop mode floats pin zero regardless enable
// - Port three eight pins, latch resets ones
// - Port four latch ones, drive type zeros
// - Drive bit: zero open-drain, one push-pull
// - Serial output on port four keeps latch
module mfio_ports
  import mfio_pkg::*;
#(
  parameter int P1_WIDTH = 8,
  parameter int P4_WIDTH = 8
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic i_global_output_enable,
  input wire logic [P1_WIDTH-1:0] i_p1_pin,
  input wire logic [P1_WIDTH-1:0] i_p1_periph_out,
  output logic [P1_WIDTH-1:0] o_p1_pin,
  output logic [P1_WIDTH-1:0] o_p1_pin_oe_n,
  input wire logic [P2_WIDTH-1:0] i_p2_pin,
  output logic [P2_WIDTH-1:0] o_p2_pin,
  output logic [P2_WIDTH-1:0] o_p2_pin_oe_n,
  input wire logic [7:0] i_p3_pin,
  output logic [7:0] o_p3_pin,
  output logic [7:0] o_p3_pin_oe_n,
  input wire logic [P4_WIDTH-1:0] i_p4_pin,
  input wire logic [P4_WIDTH-1:0] i_p4_periph_out,
  output logic [P4_WIDTH-1:0] o_p4_pin,
  output logic [P4_WIDTH-1:0] o_p4_pin_oe_n,
  output logic [P1_WIDTH-1:0] o_p1_input,
  output logic [P4_WIDTH-1:0] o_p4_input,
  output logic o_stop_release,
  output logic o_dual_clock_mode,
  output logic o_irq
);
  if (P1_WIDTH < 1 || P1_WIDTH > 8) begin : g_bad_p1_width
    $error("mfio_ports: P1_WIDTH must be 1..8");
  end
  if (P4_WIDTH < 1 || P4_WIDTH > 8) begin : g_bad_p4_width
    $error("mfio_ports: P4_WIDTH must be 1..8");
  end

  // ---------------------------------------------------------------
  // Registers and synchronised pins
  // ---------------------------------------------------------------
  logic [P1_WIDTH-1:0] port1_output_latch;
  logic [P1_WIDTH-1:0] port1_direction_control;
  logic [P2_WIDTH-1:0] port2_output_latch;
  logic [7:0] port3_output_latch;
  logic [P4_WIDTH-1:0] port4_output_latch;
  logic [P4_WIDTH-1:0] port4_drive_type;
  logic [IRQ_WIDTH-1:0] irq_status;
  logic [IRQ_WIDTH-1:0] irq_mask;
  logic [1:0] mode;
  logic [P1_WIDTH-1:0] p1_sync;
  logic [P2_WIDTH-1:0] port2_pin_input;
  logic [7:0] port3_pin_input;
  logic [P4_WIDTH-1:0] port4_pin_input;
  logic stop_pin_prev;
  logic [P4_WIDTH-1:0] p4_prev;

  mfio_sync #(.WIDTH(P1_WIDTH), .INIT('0)) u_sync_p1 (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_async(i_p1_pin), .o_level(p1_sync));
  mfio_sync #(.WIDTH(P2_WIDTH), .INIT('1)) u_sync_p2 (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_async(i_p2_pin), .o_level(port2_pin_input));
  mfio_sync #(.WIDTH(8), .INIT('1)) u_sync_p3 (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_async(i_p3_pin), .o_level(port3_pin_input));
  mfio_sync #(.WIDTH(P4_WIDTH), .INIT('1)) u_sync_p4 (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_async(i_p4_pin), .o_level(port4_pin_input));

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  function automatic logic is_reg(input logic [11:0] addr, input logic [7:0] idx);
    return (addr[11:2] == {2'h0, idx}) && (addr[1:0] == 2'h0);
  endfunction

  logic wr_acc;
  logic rd_acc;
  logic known;
  assign wr_acc = psel && penable && pwrite && pready;
  assign rd_acc = psel && !penable && !pwrite;
  assign known = is_reg(paddr, IDX_P1_LATCH) || is_reg(paddr, IDX_P2_LATCH) ||
                 is_reg(paddr, IDX_P3_LATCH) || is_reg(paddr, IDX_P4_LATCH) ||
                 is_reg(paddr, IDX_P1_DIR) || is_reg(paddr, IDX_P4_DRIVE) ||
                 is_reg(paddr, IDX_P2_PIN) || is_reg(paddr, IDX_P3_PIN) ||
                 is_reg(paddr, IDX_P4_PIN) || is_reg(paddr, IDX_IRQ_STATUS) ||
                 is_reg(paddr, IDX_IRQ_MASK) || is_reg(paddr, IDX_MODE);

  logic wr_en;
  assign wr_en = wr_acc && known && pstrb[0];

  // Slave answers one cycle after setup: pready registered high for the access
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !known;
    end
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  logic [31:0] next_prdata;
  always_comb begin
    next_prdata = 32'h0;
    if (is_reg(paddr, IDX_P1_LATCH)) begin
      // Outputs read the latch, inputs read the pin
      next_prdata[P1_WIDTH-1:0] = (port1_direction_control & port1_output_latch) |
                                  (~port1_direction_control & p1_sync);
    end else if (is_reg(paddr, IDX_P2_LATCH)) begin
      // Bits 7..3 are undefined; zero is chosen
      next_prdata[P2_WIDTH-1:0] = port2_output_latch;
    end else if (is_reg(paddr, IDX_P2_PIN)) begin
      next_prdata[P2_WIDTH-1:0] = port2_pin_input;
    end else if (is_reg(paddr, IDX_P3_LATCH)) begin
      next_prdata[7:0] = port3_output_latch;
    end else if (is_reg(paddr, IDX_P3_PIN)) begin
      next_prdata[7:0] = port3_pin_input;
    end else if (is_reg(paddr, IDX_P4_LATCH)) begin
      next_prdata[P4_WIDTH-1:0] = port4_output_latch;
    end else if (is_reg(paddr, IDX_P4_PIN)) begin
      next_prdata[P4_WIDTH-1:0] = port4_pin_input;
    end else if (is_reg(paddr, IDX_P1_DIR)) begin
      next_prdata[P1_WIDTH-1:0] = port1_direction_control;
    end else if (is_reg(paddr, IDX_P4_DRIVE)) begin
      next_prdata[P4_WIDTH-1:0] = port4_drive_type;
    end else if (is_reg(paddr, IDX_IRQ_STATUS)) begin
      next_prdata[IRQ_WIDTH-1:0] = irq_status;
    end else if (is_reg(paddr, IDX_IRQ_MASK)) begin
      next_prdata[IRQ_WIDTH-1:0] = irq_mask;
    end else if (is_reg(paddr, IDX_MODE)) begin
      next_prdata[1:0] = mode;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prdata <= 32'h0;
    end else if (rd_acc) begin
      prdata <= next_prdata;
    end
  end

  // ---------------------------------------------------------------
  // Writable registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      port1_output_latch <= RST_P1_LATCH[P1_WIDTH-1:0];
      port1_direction_control <= RST_P1_DIR[P1_WIDTH-1:0];
    end else if (wr_en) begin
      if (is_reg(paddr, IDX_P1_LATCH)) port1_output_latch <= pwdata[P1_WIDTH-1:0];
      if (is_reg(paddr, IDX_P1_DIR)) port1_direction_control <= pwdata[P1_WIDTH-1:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      port2_output_latch <= RST_P2_LATCH;
      port3_output_latch <= RST_P3_LATCH;
    end else if (wr_en) begin
      if (is_reg(paddr, IDX_P2_LATCH)) port2_output_latch <= pwdata[P2_WIDTH-1:0];
      if (is_reg(paddr, IDX_P3_LATCH)) port3_output_latch <= pwdata[7:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      port4_output_latch <= RST_P4_LATCH[P4_WIDTH-1:0];
      port4_drive_type <= RST_P4_DRIVE[P4_WIDTH-1:0];
    end else if (wr_en) begin
      if (is_reg(paddr, IDX_P4_LATCH)) port4_output_latch <= pwdata[P4_WIDTH-1:0];
      if (is_reg(paddr, IDX_P4_DRIVE)) port4_drive_type <= pwdata[P4_WIDTH-1:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode <= RST_MODE;
      irq_mask <= RST_IRQ_MASK;
    end else if (wr_en) begin
      if (is_reg(paddr, IDX_MODE)) mode <= pwdata[1:0];
      if (is_reg(paddr, IDX_IRQ_MASK)) irq_mask <= pwdata[IRQ_WIDTH-1:0];
    end
  end

  // ---------------------------------------------------------------
  // Interrupt events
  // ---------------------------------------------------------------
  logic [IRQ_WIDTH-1:0] event_set;
  logic [IRQ_WIDTH-1:0] clr_bits;
  assign event_set[IRQ_STOP_FALL_BIT] = stop_pin_prev && !port2_pin_input[P2_STOP_PIN];
  assign event_set[IRQ_P4_CHANGE_BIT] = |(p4_prev ^ port4_pin_input);
  assign clr_bits = (wr_en && is_reg(paddr, IDX_IRQ_STATUS)) ?
                    pwdata[IRQ_WIDTH-1:0] : '0;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stop_pin_prev <= 1'b1;
      p4_prev <= '1;
    end else begin
      stop_pin_prev <= port2_pin_input[P2_STOP_PIN];
      p4_prev <= port4_pin_input;
    end
  end

  // Falling edge is seen on the pin even when the latch drives it; set beats clear
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_status <= '0;
    end else begin
      irq_status <= (irq_status & ~clr_bits) | event_set;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(((irq_status & ~clr_bits) | event_set) & irq_mask);
    end
  end

  // ---------------------------------------------------------------
  // Pin drivers (oe_n low = driving)
  // ---------------------------------------------------------------
  logic dual_clk;
  logic stop_mode;
  assign dual_clk = mode[MODE_DUAL_CLK_BIT];
  assign stop_mode = mode[MODE_STOP_BIT];

  logic [P1_WIDTH-1:0] p1_level;
  logic [P4_WIDTH-1:0] p4_level;
  assign p1_level = port1_output_latch & i_p1_periph_out;
  assign p4_level = port4_output_latch & i_p4_periph_out;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_p1_pin <= '0;
      o_p1_pin_oe_n <= '1;
    end else begin
      o_p1_pin <= p1_level;
      // Input bits float, so the latch has no effect there
      o_p1_pin_oe_n <= ~(port1_direction_control & {P1_WIDTH{i_global_output_enable}});
    end
  end

  // Port two, three: open drain low only; latch 1 releases the pin for input use
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_p2_pin <= '0;
      o_p2_pin_oe_n <= '1;
      o_p3_pin <= '0;
      o_p3_pin_oe_n <= '1;
    end else begin
      o_p2_pin <= '0;
      o_p2_pin_oe_n <= port2_output_latch | {P2_WIDTH{!i_global_output_enable}};
      if (dual_clk) begin
        o_p2_pin_oe_n[P2_XTAL_OUT_PIN] <= 1'b1;
        o_p2_pin_oe_n[P2_XTAL_IN_PIN] <= 1'b1;
      end
      if (stop_mode) o_p2_pin_oe_n[P2_STOP_PIN] <= 1'b1;
      o_p3_pin <= '0;
      o_p3_pin_oe_n <= port3_output_latch | {8{!i_global_output_enable}};
    end
  end

  // Drive 0 while global output enable is on; drive 1 only when push-pull
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_p4_pin <= '0;
      o_p4_pin_oe_n <= '1;
    end else begin
      o_p4_pin <= p4_level;
      o_p4_pin_oe_n <= ~((~p4_level | port4_drive_type) &
                         {P4_WIDTH{i_global_output_enable}});
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_p1_input <= '0;
      o_p4_input <= '1;
      o_stop_release <= 1'b1;
      o_dual_clock_mode <= 1'b0;
    end else begin
      o_p1_input <= p1_sync;
      o_p4_input <= port4_pin_input;
      o_stop_release <= port2_pin_input[P2_STOP_PIN];
      o_dual_clock_mode <= dual_clk;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  chk_p1_reset_zero: assert property (@(posedge i_clk) $rose(i_rst_n) |->
    port1_direction_control == '0 && port1_output_latch == '0)
    else $error("port one not cleared at reset");
  chk_p1_input_float: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !port1_direction_control[0] |=> o_p1_pin_oe_n[0])
    else $error("port one input bit driven");
  chk_p1_read_mix: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    rd_acc && is_reg(paddr, IDX_P1_LATCH) |=>
    prdata[P1_WIDTH-1:0] == (($past(port1_direction_control) & $past(port1_output_latch)) |
    (~$past(port1_direction_control) & $past(p1_sync))))
    else $error("port one readback wrong");
  chk_p2_upper_zero: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    rd_acc && is_reg(paddr, IDX_P2_PIN) |=> prdata[7:3] == 5'h0)
    else $error("port two upper bits nonzero");
  chk_stop_pin_fall: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $fell(port2_pin_input[P2_STOP_PIN]) |=> irq_status[IRQ_STOP_FALL_BIT])
    else $error("pin zero fall not latched");
  chk_stop_float: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    stop_mode |=> o_p2_pin_oe_n[P2_STOP_PIN])
    else $error("pin zero driven in stop");
  chk_xtal_float: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    dual_clk |=> o_p2_pin_oe_n[P2_XTAL_IN_PIN] && o_p2_pin_oe_n[P2_XTAL_OUT_PIN])
    else $error("crystal pins driven");
  chk_p4_open_drain: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !port4_drive_type[0] && p4_level[0] |=> o_p4_pin_oe_n[0])
    else $error("open drain drove high");
  chk_p4_shared_and: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    1'b1 |=> o_p4_pin == ($past(port4_output_latch) & $past(i_p4_periph_out)))
    else $error("port four level not latch AND periph");
  chk_latch_reset_one: assert property (@(posedge i_clk) $rose(i_rst_n) |->
    port3_output_latch == 8'hff && port2_output_latch == 3'h7 && port4_drive_type == '0)
    else $error("latch reset values wrong");
endmodule

// >>> hw/mfio_pkg.sv
// Package: register map, reset values and field positions of the port block
package mfio_pkg;
  // Register indices (printed offsets are not all multiples of four)
  localparam logic [7:0] IDX_P1_LATCH = 8'h01;
  localparam logic [7:0] IDX_P2_LATCH = 8'h02;
  localparam logic [7:0] IDX_P3_LATCH = 8'h03;
  localparam logic [7:0] IDX_P4_LATCH = 8'h04;
  localparam logic [7:0] IDX_P1_DIR = 8'h09;
  localparam logic [7:0] IDX_P4_DRIVE = 8'h0a;
  localparam logic [7:0] IDX_P2_PIN = 8'h0c;
  localparam logic [7:0] IDX_P3_PIN = 8'h0d;
  localparam logic [7:0] IDX_P4_PIN = 8'h0e;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h10;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h11;
  localparam logic [7:0] IDX_MODE = 8'h12;
  // Reset values
  localparam logic [7:0] RST_P1_LATCH = 8'h00;
  localparam logic [7:0] RST_P1_DIR = 8'h00;
  localparam logic [2:0] RST_P2_LATCH = 3'h7;
  localparam logic [7:0] RST_P3_LATCH = 8'hff;
  localparam logic [7:0] RST_P4_LATCH = 8'hff;
  localparam logic [7:0] RST_P4_DRIVE = 8'h00;
  localparam logic [1:0] RST_IRQ_MASK = 2'h0;
  localparam logic [1:0] RST_MODE = 2'h0;
  // Field positions
  localparam int MODE_DUAL_CLK_BIT = 0;
  localparam int MODE_STOP_BIT = 1;
  localparam int IRQ_STOP_FALL_BIT = 0;
  localparam int IRQ_P4_CHANGE_BIT = 1;
  localparam int P2_STOP_PIN = 0;
  localparam int P2_XTAL_IN_PIN = 1;
  localparam int P2_XTAL_OUT_PIN = 2;
  localparam int P2_WIDTH = 3;
  localparam int IRQ_WIDTH = 2;
  localparam int SYNC_STAGES = 3;
endpackage

// >>> hw/mfio_sync.sv
// Three-stage pin synchroniser with second/third agreement filter
`timescale 1ns/100ps
module mfio_sync #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_level
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  if (WIDTH < 1) begin : g_bad_width
    $error("mfio_sync: WIDTH must be positive");
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stage1 <= INIT;
      stage2 <= INIT;
      stage3 <= INIT;
    end else begin
      stage1 <= i_async;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // Per bit: only a level seen twice in a row is accepted
  logic [WIDTH-1:0] next_level;
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      assign next_level[g] = (stage2[g] == stage3[g]) ? stage3[g] : o_level[g];
    end
  endgenerate

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_level <= INIT;
    end else begin
      o_level <= next_level;
    end
  end
endmodule

// >>> testbench/mfio_pin_model.sv
// Partner model: external pins with pull-ups and an optional outside driver
`timescale 1ns/100ps
module mfio_pin_model #(
  parameter int WIDTH = 8
) (
  input wire logic [WIDTH-1:0] i_pin,
  input wire logic [WIDTH-1:0] i_pin_oe_n,
  input wire logic [WIDTH-1:0] i_ext_en,
  input wire logic [WIDTH-1:0] i_ext_val,
  output logic [WIDTH-1:0] o_level
);
  // Released lines fall to the pull-up unless driven from outside, never keep the last driven value
  assign o_level = (~i_pin_oe_n & i_pin) | (i_pin_oe_n & i_ext_en & i_ext_val) |
    (i_pin_oe_n & ~i_ext_en);
endmodule

// >>> testbench/mfio_ports_tb_top.sv
// Testbench: register, pin, mode and interrupt checks of the port block
`timescale 1ns/100ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module mfio_ports_tb_top;
  import mfio_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic goe = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, irq, stop_rel, dual;
  logic [7:0] per1 = 8'hff, per4 = 8'hff, e1 = 8'h00, v1 = 8'h00, e3 = 8'h00, v3 = 8'h00;
  logic [7:0] e4 = 8'h00, v4 = 8'h00;
  logic [2:0] e2 = 3'h0, v2 = 3'h0;
  logic [3:0] strb = 4'hf;
  logic [7:0] p1_in, p1_out, p1_oe_n, p3_in, p3_out, p3_oe_n, p4_in, p4_out, p4_oe_n;
  logic [7:0] p1_sync, p4_sync, dir, lat, ext, lat3, ext3, lat4, drv4, eff;
  logic [2:0] p2_in, p2_out, p2_oe_n;
  logic [15:0] s = 16'h1aca;
  logic [7:0] ridx [7] = '{IDX_P2_LATCH, IDX_P3_LATCH, IDX_P4_LATCH, IDX_P1_DIR,
    IDX_P4_DRIVE, IDX_P2_PIN, IDX_IRQ_MASK};
  logic [7:0] rexp [7] = '{8'h07, 8'hff, 8'hff, 8'h00, 8'h00, 8'h07, 8'h00};
  int n_errors = 0;
  int checks = 0;
  int cyc = 0;

  always #50 i_clk = ~i_clk;

  mfio_ports u_mfio_ports (.i_clk(i_clk), .i_rst_n(i_rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(strb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .i_global_output_enable(goe), .i_p1_pin(p1_in),
    .i_p1_periph_out(per1), .o_p1_pin(p1_out), .o_p1_pin_oe_n(p1_oe_n), .i_p2_pin(p2_in),
    .o_p2_pin(p2_out), .o_p2_pin_oe_n(p2_oe_n), .i_p3_pin(p3_in), .o_p3_pin(p3_out),
    .o_p3_pin_oe_n(p3_oe_n), .i_p4_pin(p4_in), .i_p4_periph_out(per4), .o_p4_pin(p4_out),
    .o_p4_pin_oe_n(p4_oe_n), .o_p1_input(p1_sync), .o_p4_input(p4_sync),
    .o_stop_release(stop_rel), .o_dual_clock_mode(dual), .o_irq(irq));
  mfio_pin_model #(.WIDTH(8)) u_mfio_pin_model_p1 (.i_pin(p1_out), .i_pin_oe_n(p1_oe_n),
    .i_ext_en(e1), .i_ext_val(v1), .o_level(p1_in));
  mfio_pin_model #(.WIDTH(3)) u_mfio_pin_model_p2 (.i_pin(p2_out), .i_pin_oe_n(p2_oe_n),
    .i_ext_en(e2), .i_ext_val(v2), .o_level(p2_in));
  mfio_pin_model #(.WIDTH(8)) u_mfio_pin_model_p3 (.i_pin(p3_out), .i_pin_oe_n(p3_oe_n),
    .i_ext_en(e3), .i_ext_val(v3), .o_level(p3_in));
  mfio_pin_model #(.WIDTH(8)) u_mfio_pin_model_p4 (.i_pin(p4_out), .i_pin_oe_n(p4_oe_n),
    .i_ext_en(e4), .i_ext_val(v4), .o_level(p4_in));

  // ------------------------------------------------------------
  // Bus master and helpers
  // ------------------------------------------------------------
  task automatic results();
    if (n_errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  // Read data lands in rd, error flag in err
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge i_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge i_clk);
    penable <= 1'b1;
    // Only the bench timeout ends a wait for the slave
    do begin
      @(posedge i_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  function automatic logic [7:0] f_sel(input logic [7:0] m, input logic [7:0] a,
    input logic [7:0] b);
    return (m & a) | (~m & b);
  endfunction

  // Cuts a hang short well above the roughly 700 cycles needed
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 6000) begin
      n_errors++;
      results();
    end
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    tick(12);
    i_rst_n <= 1'b1;
    foreach (ridx[k]) begin
      apb(1'b0, ridx[k], 8'h00);
      `CHK(rd, {24'h0, rexp[k]})
    end
    `CHK(p4_oe_n, 8'hff)
    apb(1'b1, IDX_P1_DIR, 8'hff);
    apb(1'b0, IDX_P1_LATCH, 8'h00);
    `CHK(rd, 32'h0)
    apb(1'b1, IDX_P1_DIR, 8'h0f);
    tick(8);
    apb(1'b0, IDX_P1_LATCH, 8'h00);
    `CHK(rd, 32'hf0)
    apb(1'b1, IDX_P1_LATCH, rd[7:0] | 8'h01);
    apb(1'b1, IDX_P1_DIR, 8'hff);
    apb(1'b0, IDX_P1_LATCH, 8'h00);
    `CHK(rd, 32'hf1)
    repeat (16) begin
      s = lfsr(s);
      dir = s[7:0];
      lat = s[15:8];
      s = lfsr(s);
      ext = s[7:0];
      per1 <= s[15:8];
      s = lfsr(s);
      lat3 = s[7:0];
      ext3 = s[15:8];
      s = lfsr(s);
      lat4 = s[7:0];
      drv4 = s[15:8];
      s = lfsr(s);
      per4 <= s[7:0];
      e1 <= ~dir;
      v1 <= ext;
      e3 <= lat3;
      v3 <= ext3;
      apb(1'b1, IDX_P1_LATCH, lat);
      apb(1'b1, IDX_P1_DIR, dir);
      apb(1'b1, IDX_P3_LATCH, lat3);
      apb(1'b1, IDX_P4_LATCH, lat4);
      apb(1'b1, IDX_P4_DRIVE, drv4);
      tick(8);
      eff = lat4 & per4;
      apb(1'b0, IDX_P1_LATCH, 8'h00);
      `CHK(rd[7:0], f_sel(dir, lat, ext))
      `CHK(p1_oe_n, ~dir)
      `CHK(p1_out & dir, lat & per1 & dir)
      `CHK(p1_sync, f_sel(dir, lat & per1, ext))
      apb(1'b0, IDX_P3_LATCH, 8'h00);
      `CHK(rd[7:0], lat3)
      `CHK(p3_oe_n, lat3)
      apb(1'b0, IDX_P3_PIN, 8'h00);
      `CHK(rd[7:0], lat3 & ext3)
      apb(1'b0, IDX_P4_PIN, 8'h00);
      `CHK(rd[7:0], eff)
      `CHK(p4_sync, eff)
      `CHK(p4_oe_n, eff & ~drv4)
      `CHK(p4_out & ~p4_oe_n, eff & drv4)
    end
    apb(1'b1, IDX_IRQ_MASK, 8'h03);
    apb(1'b1, IDX_IRQ_STATUS, 8'h03);
    apb(1'b1, IDX_P2_LATCH, 8'h00);
    tick(8);
    `CHK({p2_oe_n, stop_rel}, 4'h0)
    apb(1'b0, IDX_IRQ_STATUS, 8'h00);
    `CHK({rd[1:0], irq}, 3'b011)
    apb(1'b1, IDX_IRQ_MASK, 8'h02);
    tick(2);
    `CHK(irq, 1'b0)
    per4 <= 8'hff;
    apb(1'b1, IDX_P4_LATCH, 8'hff);
    apb(1'b1, IDX_P4_DRIVE, 8'h00);
    tick(8);
    apb(1'b1, IDX_IRQ_STATUS, 8'h02);
    e4 <= 8'h01;
    tick(8);
    `CHK({p4_sync, irq}, 9'h1fd)
    apb(1'b1, IDX_IRQ_STATUS, 8'h03);
    tick(2);
    `CHK(irq, 1'b0)
    apb(1'b1, IDX_MODE, 8'h01);
    tick(2);
    `CHK({p2_oe_n, dual}, 4'hd)
    apb(1'b1, IDX_MODE, 8'h02);
    tick(2);
    `CHK(p2_oe_n, 3'h1)
    goe <= 1'b0;
    apb(1'b1, IDX_MODE, 8'h00);
    tick(2);
    `CHK({p1_oe_n, p2_oe_n, p3_oe_n, p4_oe_n}, 27'h7ffffff)
    `CHK({p2_out, p3_out}, 11'h0)
    goe <= 1'b1;
    apb(1'b1, IDX_P2_LATCH, 8'h07);
    e2 <= 3'h6;
    v2 <= 3'h2;
    tick(8);
    apb(1'b0, IDX_P2_PIN, 8'h00);
    `CHK(rd, 32'h3)
    strb <= 4'he;
    apb(1'b1, IDX_P3_LATCH, 8'h5a);
    strb <= 4'hf;
    apb(1'b0, IDX_P3_LATCH, 8'h00);
    `CHK(rd[7:0], lat3)
    apb(1'b0, 8'hfe, 8'h00);
    `CHK({err, rd}, 33'h100000000)
    results();
  end
endmodule
